// ===== bench/fmt_checker.sv
`timescale 1ns/1ps
`default_nettype none
module fmt_checker
    import formatter_pkg::*;
(
    // Clock and reset
    input wire logic                 mclk,
    input wire logic                 resetn,
    // Processor bus
    input wire logic [BASE_BITS-1:0] addr_upper,
    input wire logic [BASE_BITS-1:0] base_switch,
    input wire logic                 port_select_bit,
    input wire logic                 write_not_read,
    input wire logic                 io_enable_n,
    input wire logic [BUS_BITS-1:0]  data_out,
    input wire logic                 data_oe,
    // Serial and reference lines
    input wire logic                 bit_clk,
    input wire logic                 tx_serial,
    input wire logic                 frame_zero_pulse,
    // Debug latches
    input wire logic [BUS_BITS-1:0]  debug1,
    input wire logic [BUS_BITS-1:0]  debug2,
    input wire logic [BUS_BITS-1:0]  debug3
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!resetn);

    logic       sel;
    logic [3:0] hi_age_q;
    assign sel = (addr_upper == base_switch);

    // Cycles since bit clock rose; tx may move only shortly after, or while enable is low
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            hi_age_q <= 4'hf;
        else if (!bit_clk)
            hi_age_q <= 4'h0;
        else if (hi_age_q != 4'hf)
            hi_age_q <= hi_age_q + 4'h1;
    end

    ////////////////////////////////////////////////////////////////////
    chk_oe_read:
        assert property (data_oe |-> !write_not_read)
        else $error("bus driven outside a read");
    chk_oe_select:
        assert property (data_oe |-> sel)
        else $error("bus driven for another base");
    chk_oe_cause:
        assert property ($rose(data_oe) |-> !$past(io_enable_n, 2))
        else $error("bus driven without enable");
    chk_oe_release:
        assert property ($rose(io_enable_n) |-> ##[1:6] !data_oe)
        else $error("bus not released");
    chk_upper_zero:
        assert property (data_out[15:12] == 4'h0)
        else $error("upper data lines not zero");
    chk_dbg_write:
        assert property ($changed({debug1, debug2, debug3}) |->
            !io_enable_n && write_not_read && !port_select_bit && sel)
        else $error("debug latch moved without data write");
    chk_fsync_write:
        assert property ($changed(frame_zero_pulse) |->
            !io_enable_n && write_not_read && port_select_bit && sel)
        else $error("frame pulse moved without command");
    chk_tx_tick:
        assert property ($changed(tx_serial) |->
            (hi_age_q inside {[2:9]}) || !io_enable_n)
        else $error("serial output moved off a bit tick");

    cov_read: cover property ($rose(data_oe));
    cov_fsync: cover property ($rose(frame_zero_pulse));
    cov_debug: cover property ($changed(debug3));
endmodule
`default_nettype wire

// ===== bench/serial_analyzer.sv
`timescale 1ns/1ps
`default_nettype none
module serial_analyzer #(
    parameter int HALF_NS = 160
) (
    // Control from bench
    input  wire logic   go,
    output logic        busy,
    // Serial lines
    output logic        bit_clk,
    output logic        rx_serial,
    input  wire logic   tx_serial,
    // Captured and sent words
    output logic [11:0] tx_got,
    output logic        tx_stb,
    output logic [11:0] rx_word,
    output logic        rx_stb
);
    logic [11:0] w;
    initial
    begin
        {busy, bit_clk, rx_serial, tx_stb, rx_stb} = 5'h00;
        tx_got = 12'h000;
        rx_word = 12'h000;
    end
    // Clock runs for whole words only, keeping word alignment
    always @(posedge go)
    begin
        busy = 1'b1;
        w = 12'($urandom);
        rx_word = w;
        rx_stb = 1'b1;
        for (int b = 11; b >= 0; b--)
        begin
            rx_serial = w[b];
            #HALF_NS bit_clk = 1'b1;
            #HALF_NS bit_clk = 1'b0;
            tx_got[b] = tx_serial;
        end
        // Released line must not keep its last value
        rx_serial = ~rx_serial;
        rx_stb = 1'b0;
        tx_stb = 1'b1;
        #1 tx_stb = 1'b0;
        busy = 1'b0;
    end
endmodule
`default_nettype wire

// ===== bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
    import formatter_pkg::*;
;
    logic mclk, resetn, port_select_bit, write_not_read, io_enable_n;
    logic bit_clk, rx_serial, tx_serial, frame_zero_in, frame_zero_pulse;
    logic data_oe, go, busy, tx_stb, rx_stb, oe_q;
    logic [BASE_BITS-1:0] addr_upper, base_switch;
    logic [BUS_BITS-1:0]  data_in, data_out, debug1, debug2, debug3, w;
    logic [BUS_BITS-1:0]  dbg [3];
    logic [BUS_BITS-1:0]  exp_q[$], tx_q[$], rx_q[$];
    logic [WORD_BITS-1:0] tx_got, rx_word;
    int num_errors = 0;
    int tests_run = 0;
    int cycles = 0;

    serial_word_formatter_board dut_u (.mclk(mclk), .resetn(resetn),
        .addr_upper(addr_upper), .port_select_bit(port_select_bit),
        .write_not_read(write_not_read), .io_enable_n(io_enable_n),
        .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
        .base_switch(base_switch), .bit_clk(bit_clk),
        .rx_serial(rx_serial), .tx_serial(tx_serial),
        .frame_zero_in(frame_zero_in), .frame_zero_pulse(frame_zero_pulse),
        .debug1(debug1), .debug2(debug2), .debug3(debug3));
    serial_analyzer far_u (.go(go), .busy(busy), .bit_clk(bit_clk),
        .rx_serial(rx_serial), .tx_serial(tx_serial), .tx_got(tx_got),
        .tx_stb(tx_stb), .rx_word(rx_word), .rx_stb(rx_stb));

    ////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            num_errors++;
            $display("MISMATCH %0t got %h want %h", $time, got, exp);
        end
    endtask

    task automatic test_done();
        $display("errors %0d compares %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Reads note their expected value; the watcher below compares it
    task automatic bus(input logic ps, input logic wr,
                       input logic [15:0] d, input logic [15:0] e,
                       input bit sel = 1'b1);
        if (!wr)
            exp_q.push_back(e);
        @(posedge mclk);
        port_select_bit <= ps;
        write_not_read <= wr;
        data_in <= d;
        addr_upper <= sel ? base_switch : ~base_switch;
        @(posedge mclk) io_enable_n <= 1'b0;
        repeat (8) @(posedge mclk);
        io_enable_n <= 1'b1;
        repeat (8) @(posedge mclk);
    endtask

    ////////////////////////////////////////////////////////////////////
    initial
    begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    always @(posedge mclk)
    begin
        oe_q <= data_oe;
        if (oe_q === 1'b1 && data_oe === 1'b0)
            check(data_out, exp_q.pop_front());
        cycles++;
        if (cycles == 20000)
        begin
            num_errors++;
            test_done();
        end
    end

    always @(posedge tx_stb)
        check({4'h0, tx_got}, tx_q.pop_front());
    always @(posedge rx_stb)
        rx_q.push_back({4'h0, rx_word});

    initial
    begin
        void'($urandom(42392));
        {resetn, port_select_bit, write_not_read, go} = 4'h0;
        {io_enable_n, frame_zero_in, data_in} = 18'h2_0000;
        base_switch = 3'($urandom);
        addr_upper = base_switch;
        dbg = '{default: DEBUG_RESET};
        repeat (2) @(posedge mclk);
        resetn <= 1'b1;
        repeat (4) @(posedge mclk);
        bus(1'b1, 1'b0, 16'h0000, 16'h0004);
        bus(1'b1, 1'b1, 16'h0000, 16'h0000);
        // Four words back to back, then two starved bursts
        for (int i = 0; i < 6; i++)
        begin
            if (i < 4)
            begin
                w = 16'($urandom);
                tx_q.push_back({4'h0, w[11:0]});
                bus(1'b0, 1'b1, w, 16'h0000);
                if (i == 0)
                    bus(1'b1, 1'b0, 16'h0000, 16'h0000);
            end
            else
                tx_q.push_back(16'h0000);
            go <= 1'b1;
            @(posedge mclk) go <= 1'b0;
            @(posedge mclk);
            wait (!busy);
            w = {12'h000, i >= 4, 1'b1, i >= 3, 1'b1};
            bus(1'b1, 1'b0, 16'h0000, w);
            if (i != 2)
                bus(1'b0, 1'b0, 16'h0000, rx_q.pop_front());
            if (i == 3)
                bus(1'b0, 1'b0, 16'h0000, rx_q.pop_front());
        end
        foreach (dbg[t])
        begin
            bus(1'b1, 1'b1, 16'(t + 1), 16'h0000);
            bus(1'b0, 1'b1, 16'($urandom), 16'h0000, 1'b0);
            repeat (2)
            begin
                dbg[t] = 16'($urandom);
                bus(1'b0, 1'b1, dbg[t], 16'h0000);
            end
        end
        check(debug1, dbg[0]);
        check(debug2, dbg[1]);
        check(debug3, dbg[2]);
        bus(1'b1, 1'b0, 16'h0000, 16'h000e);
        bus(1'b1, 1'b1, 16'h0004, 16'h0000);
        check(16'(frame_zero_pulse), 16'h0001);
        frame_zero_in <= 1'b1;
        bus(1'b1, 1'b0, 16'h0000, 16'h001e);
        bus(1'b1, 1'b1, 16'h0000, 16'h0000);
        check(16'(frame_zero_pulse), 16'h0000);
        bus(1'b1, 1'b1, 16'h0004, 16'h0000);
        bus(1'b1, 1'b1, 16'h8004, 16'h0000);
        check(16'(frame_zero_pulse), 16'h0000);
        bus(1'b1, 1'b0, 16'h0000, 16'h0014);
        check(debug1, dbg[0]);
        // Receiver side: falling reference line ends frame zero
        frame_zero_in <= 1'b0;
        bus(1'b1, 1'b0, 16'h0000, 16'h0004);
        // A read that never drove the bus leaves its note behind
        check(16'(exp_q.size() + tx_q.size()), 16'h0000);
        test_done();
    end
endmodule

bind serial_word_formatter_board fmt_checker chk_u (.mclk(mclk),
    .resetn(resetn), .addr_upper(addr_upper), .base_switch(base_switch),
    .port_select_bit(port_select_bit), .write_not_read(write_not_read),
    .io_enable_n(io_enable_n), .data_out(data_out), .data_oe(data_oe),
    .bit_clk(bit_clk), .tx_serial(tx_serial),
    .frame_zero_pulse(frame_zero_pulse), .debug1(debug1),
    .debug2(debug2), .debug3(debug3));
`default_nettype wire

// ===== rtl/formatter_pkg.sv
package formatter_pkg;

    // Word and bus geometry
    localparam int WORD_BITS   = 12;
    localparam int BUS_BITS    = 16;
    localparam int BASE_BITS   = 3;
    localparam int CNT_BITS    = 4;

    // Port decode: port_select_bit, write_not_read
    localparam logic PORT_DATA = 1'b0;
    localparam logic PORT_CMD  = 1'b1;

    // Command field positions
    localparam int CMD_TGT_LSB   = 0;
    localparam int CMD_FSYNC_BIT = 2;
    localparam int CMD_RESET_BIT = 15;

    // Data-write targets
    localparam logic [1:0] TGT_TX_HOLD = 2'h0;
    localparam logic [1:0] TGT_DEBUG1  = 2'h1;
    localparam logic [1:0] TGT_DEBUG2  = 2'h2;
    localparam logic [1:0] TGT_DEBUG3  = 2'h3;

    // Status field positions
    localparam int ST_RX_READY   = 0;
    localparam int ST_RX_OVERRUN = 1;
    localparam int ST_TX_EMPTY   = 2;
    localparam int ST_TX_UNDERRUN= 3;
    localparam int ST_FSYNC_IN   = 4;

    // Reset values and the last bit count
    localparam logic [11:0] WORD_RESET  = 12'h000;
    localparam logic [15:0] DEBUG_RESET = 16'h0000;
    localparam logic [15:0] BUS_RESET   = 16'h0000;
    localparam logic [3:0]  CNT_LAST    = 4'hb;
    localparam logic [3:0]  CNT_RESET   = 4'h0;

    // Nominal serial bit rate, bits per second (external clock)
    localparam int BIT_RATE_BPS = 2400;

endpackage

// ===== rtl/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
// Three-stage synchroniser; output changes once stages two and three agree
module pin_sync
    import formatter_pkg::*;
(
    // Clock and reset
    input  wire logic mclk,
    input  wire logic resetn,
    // Signal
    input  wire logic pin_in,
    output logic      pin_out
);

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic o;
    } sync_t;

    sync_t st_q;
    sync_t st_d;

    always_comb
    begin
        st_d    = st_q;
        st_d.s1 = pin_in;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        if (st_q.s2 == st_q.s3)
        begin
            st_d.o = st_q.s3;
        end
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign pin_out = st_q.o;

endmodule
`default_nettype wire

// ===== rtl/serial_word_formatter_board.sv
`timescale 1ns/1ps
`default_nettype none
module serial_word_formatter_board
    import formatter_pkg::*;
(
    // Clock and reset
    input  wire logic                 mclk,
    input  wire logic                 resetn,
    // Processor I/O bus
    input  wire logic [BASE_BITS-1:0] addr_upper,
    input  wire logic                 port_select_bit,
    input  wire logic                 write_not_read,
    input  wire logic                 io_enable_n,
    input  wire logic [BUS_BITS-1:0]  data_in,
    output logic      [BUS_BITS-1:0]  data_out,
    output logic                      data_oe,
    // Base address switch
    input  wire logic [BASE_BITS-1:0] base_switch,
    // Serial data stream
    input  wire logic                 bit_clk,
    input  wire logic                 rx_serial,
    output logic                      tx_serial,
    // Frame-zero reference link
    input  wire logic                 frame_zero_in,
    output logic                      frame_zero_pulse,
    // Debug latches
    output logic      [BUS_BITS-1:0]  debug1,
    output logic      [BUS_BITS-1:0]  debug2,
    output logic      [BUS_BITS-1:0]  debug3
);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    logic bclk_s;
    logic rxd_s;
    logic fz_s;
    logic ioe_act_s;

    pin_sync u_sync_bclk
    (
        .mclk    (mclk),
        .resetn  (resetn),
        .pin_in  (bit_clk),
        .pin_out (bclk_s)
    );

    pin_sync u_sync_rxd
    (
        .mclk    (mclk),
        .resetn  (resetn),
        .pin_in  (rx_serial),
        .pin_out (rxd_s)
    );

    pin_sync u_sync_fz
    (
        .mclk    (mclk),
        .resetn  (resetn),
        .pin_in  (frame_zero_in),
        .pin_out (fz_s)
    );

    // Synced as active high: reset value then matches an idle bus
    pin_sync u_sync_ioe
    (
        .mclk    (mclk),
        .resetn  (resetn),
        .pin_in  (!io_enable_n),
        .pin_out (ioe_act_s)
    );

    ////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        logic                bclk_prev;
        logic                ioe_prev;
        logic [1:0]          target;
        logic                fsync_out;
        logic [WORD_BITS-1:0] tx_hold;
        logic [WORD_BITS-1:0] tx_shift;
        logic [CNT_BITS-1:0] tx_cnt;
        logic                tx_active;
        logic                tx_empty;
        logic                tx_underrun;
        logic [WORD_BITS-1:0] rx_shift;
        logic [CNT_BITS-1:0] rx_cnt;
        logic [WORD_BITS-1:0] rx_pend;
        logic                rx_pend_valid;
        logic [WORD_BITS-1:0] rx_latch;
        logic                rx_ready;
        logic                rx_overrun;
        logic [BUS_BITS-1:0] dbg1;
        logic [BUS_BITS-1:0] dbg2;
        logic [BUS_BITS-1:0] dbg3;
        logic [BUS_BITS-1:0] dout;
        logic                doe;
        logic                txd;
    } core_t;

    core_t st_q;
    core_t st_d;

    // Bus strobes, sampled on the enable's falling edge
    logic sel;
    logic access;
    logic wr_data;
    logic rd_data;
    logic wr_cmd;
    logic rd_stat;
    logic bit_tick;
    logic soft_reset;
    logic [WORD_BITS-1:0] rx_word;
    logic [BUS_BITS-1:0]  status;

    assign sel      = (addr_upper == base_switch);
    assign access   = !st_q.ioe_prev && ioe_act_s && sel;
    assign wr_data  = access && (port_select_bit == PORT_DATA)
                      && write_not_read;
    assign rd_data  = access && (port_select_bit == PORT_DATA)
                      && !write_not_read;
    assign wr_cmd   = access && (port_select_bit == PORT_CMD)
                      && write_not_read;
    assign rd_stat  = access && (port_select_bit == PORT_CMD)
                      && !write_not_read;
    // Rising edge of the bit clock is the transfer sequencing strobe
    assign bit_tick   = bclk_s && !st_q.bclk_prev;
    assign soft_reset = wr_cmd && data_in[CMD_RESET_BIT];
    assign rx_word    = {st_q.rx_shift[WORD_BITS-2:0], rxd_s};

    always_comb
    begin
        status                 = BUS_RESET;
        status[ST_RX_READY]    = st_q.rx_ready;
        status[ST_RX_OVERRUN]  = st_q.rx_overrun;
        status[ST_TX_EMPTY]    = st_q.tx_empty;
        status[ST_TX_UNDERRUN] = st_q.tx_underrun;
        status[ST_FSYNC_IN]    = fz_s;
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb
    begin
        st_d           = st_q;
        st_d.bclk_prev = bclk_s;
        st_d.ioe_prev  = ioe_act_s;
        st_d.doe       = ioe_act_s && sel && !write_not_read;

        // Bus side: reads and writes of the two ports
        if (rd_stat)
        begin
            st_d.dout = status;
        end
        if (rd_data)
        begin
            st_d.dout = {{(BUS_BITS-WORD_BITS){1'b0}}, st_q.rx_latch};
            st_d.rx_ready = 1'b0;
        end
        if (wr_cmd)
        begin
            st_d.target    = data_in[CMD_TGT_LSB +: 2];
            st_d.fsync_out = data_in[CMD_FSYNC_BIT];
        end
        if (wr_data)
        begin
            case (st_q.target)
                TGT_TX_HOLD:
                begin
                    st_d.tx_hold  = data_in[WORD_BITS-1:0];
                    st_d.tx_empty = 1'b0;
                end
                // Debug writes touch nothing else
                TGT_DEBUG1: st_d.dbg1 = data_in;
                TGT_DEBUG2: st_d.dbg2 = data_in;
                TGT_DEBUG3: st_d.dbg3 = data_in;
                default:    st_d.dbg1 = st_q.dbg1;
            endcase
        end

        // Pending receive word moves up once the latch is free
        if (st_q.rx_pend_valid && (!st_q.rx_ready || rd_data))
        begin
            st_d.rx_latch      = st_q.rx_pend;
            st_d.rx_ready      = 1'b1;
            st_d.rx_pend_valid = 1'b0;
        end

        if (bit_tick)
        begin
            // Transmit: one bit per tick, MSB first
            if (st_q.tx_active && st_q.tx_cnt != CNT_LAST)
            begin
                st_d.tx_shift = {st_q.tx_shift[WORD_BITS-2:0], 1'b0};
                st_d.tx_cnt   = st_q.tx_cnt + 4'h1;
                st_d.txd      = st_q.tx_shift[WORD_BITS-2];
            end
            else if (!st_d.tx_empty)
            begin
                // Hold write in this same cycle still counts
                st_d.tx_shift  = st_d.tx_hold;
                st_d.txd       = st_d.tx_hold[WORD_BITS-1];
                st_d.tx_cnt    = CNT_RESET;
                st_d.tx_active = 1'b1;
                st_d.tx_empty  = 1'b1;
            end
            else
            begin
                st_d.tx_active = 1'b0;
                st_d.txd       = 1'b0;
                if (st_q.tx_active)
                begin
                    st_d.tx_underrun = 1'b1;
                end
            end

            // Receive: gather bits, hand over each full word
            if (st_q.rx_cnt == CNT_LAST)
            begin
                st_d.rx_cnt = CNT_RESET;
                if (st_d.rx_ready)
                begin
                    // Latch unread: pending copy replaces older word
                    st_d.rx_overrun    = 1'b1;
                    st_d.rx_pend       = rx_word;
                    st_d.rx_pend_valid = 1'b1;
                end
                else
                begin
                    st_d.rx_latch = rx_word;
                    st_d.rx_ready = 1'b1;
                end
            end
            else
            begin
                st_d.rx_cnt = st_q.rx_cnt + 4'h1;
            end
            st_d.rx_shift = rx_word;
        end

        // Software reset; debug latches keep their contents
        if (soft_reset)
        begin
            st_d.tx_shift      = WORD_RESET;
            st_d.tx_cnt        = CNT_RESET;
            st_d.tx_active     = 1'b0;
            st_d.tx_empty      = 1'b1;
            st_d.tx_underrun   = 1'b0;
            st_d.txd           = 1'b0;
            st_d.rx_shift      = WORD_RESET;
            st_d.rx_cnt        = CNT_RESET;
            st_d.rx_pend_valid = 1'b0;
            st_d.rx_ready      = 1'b0;
            st_d.rx_overrun    = 1'b0;
            st_d.fsync_out     = 1'b0;
            st_d.target        = TGT_TX_HOLD;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            st_q          <= '0;
            st_q.tx_empty <= 1'b1;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // Frame-zero line follows the written bit; software makes the pulse
    assign frame_zero_pulse = st_q.fsync_out;
    assign tx_serial        = st_q.txd;
    assign data_out         = st_q.dout;
    assign data_oe          = st_q.doe;
    assign debug1           = st_q.dbg1;
    assign debug2           = st_q.dbg2;
    assign debug3           = st_q.dbg3;

endmodule
`default_nettype wire
